// ---- rtl/cis_pkg.sv ----
// ********************************************
// Card information structure constants
// ********************************************
package cis_pkg;

	// Host attribute-memory port widths
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int IDX_W = 11;

	// Maker identification tuple
	localparam logic [7:0] MID_CODE = 8'h20;
	localparam logic [7:0] MID_LINK_MIN = 8'h04;
	localparam int MID_HDR = 2;

	// Configuration tuple
	localparam logic [7:0] CFG_CODE = 8'h1A;
	localparam int CFG_FIXED_LINK = 5;
	localparam int CFG_FIXED_LEN = 4;
	localparam int SIZE_BASE_LSB = 0;
	localparam int SIZE_MASK_LSB = 2;
	localparam logic [11:0] BASE_MAX = 12'hFFE;
	localparam int SUB_AREA_LEN = 19;

	// Custom interface identification sub-tuple
	localparam logic [7:0] SUB_CODE = 8'hC0;
	localparam logic [7:0] SUB_LINK = 8'h0B;
	localparam logic [7:0] IF_NUMBER = 8'h41;
	localparam logic [7:0] IF_NUMBER_EXT = 8'h03;
	localparam int SUB_STR_AT = 4;
	localparam int NAME_LEN = 9;
	localparam int SUB_NULL_AT = 13;
	localparam int SUB_END_AT = 14;

	// Byte values
	localparam logic [7:0] NULL_BYTE = 8'h00;
	localparam logic [7:0] CHAIN_END = 8'hFF;
	localparam logic [7:0] UNMAPPED = 8'h00;
	localparam logic [7:0] RDATA_IDLE = 8'h00;

	// Write monitor status byte, outside the tuple area
	localparam logic [11:0] STAT_ADDR = 12'h7F0;
	localparam int STAT_CLR_BIT = 0;

endpackage : cis_pkg

// ---- rtl/cis_addr_dec.sv ----
`timescale 1ns/1ps
// ********************************************
// Attribute address decode
// ********************************************
module cis_addr_dec (
	input logic [cis_pkg::ADDR_W-1:0] addr,
	output logic [cis_pkg::IDX_W-1:0] byte_idx,
	output logic even_hit,
	output logic stat_hit
);

	// Byte n of the structure sits at address 2n
	assign byte_idx = addr[cis_pkg::ADDR_W-1:1]; // [RQ15]
	// Odd addresses never carry tuple data
	assign even_hit = ~addr[0]; // [RQ15]
	assign stat_hit = (addr == cis_pkg::STAT_ADDR);

endmodule : cis_addr_dec

// ---- rtl/cis_name_rom.sv ----
`timescale 1ns/1ps
// ********************************************
// Interface name string store
// ********************************************
module cis_name_rom #(
	parameter logic [8*cis_pkg::NAME_LEN-1:0] NAME = "XIF_V1.00" // Arbitrary neutral name
) (
	input logic [4:0] char_idx,
	output logic [7:0] char_byte
);

	// First character is in the top byte; past the end reads the null
	always_comb begin
		if (int'(char_idx) < cis_pkg::NAME_LEN) begin
			char_byte = NAME[8*(cis_pkg::NAME_LEN-1-int'(char_idx)) +: 8]; // [RQ14]
		end else begin
			char_byte = cis_pkg::NULL_BYTE; // [RQ14]
		end
	end

endmodule : cis_name_rom

// ---- rtl/cis_rom.sv ----
`timescale 1ns/1ps
// Operation
// [RQ1] Maker identification tuple byte 0 reads tuple code 0x20.
// [RQ2] Maker tuple byte 1 is the link to next tuple, at least 4.
// [RQ3] Maker tuple byte 2 is maker code, byte 3 card information.
// [RQ4] Configuration tuple byte 0 is 0x1A, byte 1 link five plus field lengths.
// [RQ5] Mask-size field holds presence-mask byte count minus one.
// [RQ6] Base-size field holds base-address byte count minus one.
// [RQ7] One byte holds the index of the last configuration entry.
// [RQ8] Host stops scanning after the entry matching the last index.
// [RQ9] Configuration register base is even and not above 0xFFE.
// [RQ10] Presence mask bit is one for an existing register, else zero.
// [RQ11] Configuration tuple holds a 19-byte sub-tuple area with interface sub-tuple.
// [RQ12] Interface sub-tuple starts with code 0xC0 then link 0x0B.
// [RQ13] Interface number byte reads 0x41.
// [RQ14] Name string from sub-tuple byte 4, null ended, then 0xFF.
// [RQ15] Tuple byte n lives at address 2n; odd addresses hold nothing.
// [RQ16] Size byte: base size low two bits, mask size above, top zero.
// [RQ17] Tuple bytes are read-only; host writes change nothing.
module cis_rom #(
	parameter logic [7:0] MID_LINK = 8'h04,
	parameter logic [7:0] MAKER_CODE = 8'h00,
	parameter logic [7:0] CARD_INFO = 8'h00,
	parameter logic [1:0] BASE_SIZE = 2'h1,
	parameter logic [1:0] MASK_SIZE = 2'h0,
	parameter logic [5:0] LAST_INDEX = 6'h00,
	parameter logic [11:0] CFG_BASE = 12'h200,
	parameter logic [31:0] PRESENCE_MASK = 32'h0000_0001,
	// Arbitrary neutral identification string
	parameter logic [8*cis_pkg::NAME_LEN-1:0] IF_NAME = "XIF_V1.00"
) (
	input logic sys_clk,
	input logic nrst,
	input logic [cis_pkg::ADDR_W-1:0] addr,
	input logic [cis_pkg::DATA_W-1:0] wdata,
	input logic wr,
	input logic rd,
	output logic [cis_pkg::DATA_W-1:0] rdata,
	output logic wr_seen
);

	// ********************************************
	// Layout of the structure
	// ********************************************

	// Link never below its floor, so a short setting cannot hide the next tuple
	localparam logic [7:0] MID_LINK_EFF = (MID_LINK < cis_pkg::MID_LINK_MIN) ?
		cis_pkg::MID_LINK_MIN : MID_LINK; // [RQ2]

	localparam int BASE_N = int'(BASE_SIZE) + 1; // [RQ6]
	localparam int MASK_M = int'(MASK_SIZE) + 1; // [RQ5]
	// Placed where the advertised link points, not where the raw setting would
	localparam int CFG_AT = cis_pkg::MID_HDR + int'(MID_LINK_EFF); // [RQ2]
	localparam int BASE_AT = CFG_AT + cis_pkg::CFG_FIXED_LEN;
	localparam int MASK_AT = BASE_AT + BASE_N;
	localparam int SUB_AT = MASK_AT + MASK_M;
	localparam int CEND_AT = SUB_AT + cis_pkg::SUB_AREA_LEN;
	localparam int CIS_LEN = CEND_AT + 1;
	localparam int CFG_LINK_I = cis_pkg::CFG_FIXED_LINK + BASE_N + MASK_M + cis_pkg::SUB_AREA_LEN;
	localparam logic [7:0] CFG_LINK = 8'(CFG_LINK_I); // [RQ4]

	// Base forced even and clamped to the top legal byte
	localparam logic [11:0] BASE_EFF = (CFG_BASE > cis_pkg::BASE_MAX) ?
		cis_pkg::BASE_MAX : {CFG_BASE[11:1], 1'b0}; // [RQ9]

	// Size byte packing
	localparam logic [7:0] SIZE_BYTE = (8'(MASK_SIZE) << cis_pkg::SIZE_MASK_LSB) |
		(8'(BASE_SIZE) << cis_pkg::SIZE_BASE_LSB); // [RQ16]

	// ********************************************
	// Address decode and name lookup
	// ********************************************

	logic [cis_pkg::IDX_W-1:0] byte_idx;
	logic even_hit;
	logic stat_hit;
	logic [4:0] char_idx;
	logic [7:0] char_byte;
	int idx_i;
	int sub_k;

	cis_addr_dec u_dec (
		.addr(addr),
		.byte_idx(byte_idx),
		.even_hit(even_hit),
		.stat_hit(stat_hit)
	);

	// Offset inside the sub-tuple area and character position in the name
	always_comb begin
		idx_i = int'(byte_idx);
		sub_k = idx_i - SUB_AT;
		if (sub_k >= cis_pkg::SUB_STR_AT && sub_k < cis_pkg::SUB_AREA_LEN) begin
			char_idx = 5'(sub_k - cis_pkg::SUB_STR_AT);
		end else begin
			char_idx = 5'h1F;
		end
	end

	cis_name_rom #(
		.NAME(IF_NAME)
	) u_name (
		.char_idx(char_idx),
		.char_byte(char_byte)
	);

	// ********************************************
	// Byte image
	// ********************************************

	// One byte of the structure by index; pure lookup, nothing stored
	function automatic logic [7:0] cis_byte(input int i, input logic [7:0] ch);
		int k;
		logic [7:0] b;
		k = i - SUB_AT;
		b = cis_pkg::UNMAPPED;
		if (i == 0) begin
			b = cis_pkg::MID_CODE; // [RQ1]
		end else if (i == 1) begin
			b = MID_LINK_EFF; // [RQ2]
		end else if (i == 2) begin
			b = MAKER_CODE; // [RQ3]
		end else if (i == 3) begin
			b = CARD_INFO; // [RQ3]
		end else if (i < CFG_AT) begin
			b = cis_pkg::NULL_BYTE;
		end else if (i == CFG_AT) begin
			b = cis_pkg::CFG_CODE; // [RQ4]
		end else if (i == CFG_AT + 1) begin
			b = CFG_LINK; // [RQ4]
		end else if (i == CFG_AT + 2) begin
			b = SIZE_BYTE; // [RQ5] [RQ6] [RQ16]
		end else if (i == CFG_AT + 3) begin
			b = {2'b00, LAST_INDEX}; // [RQ7]
		end else if (i < MASK_AT) begin
			// Base address, least significant byte first
			b = (i - BASE_AT < 2) ? BASE_EFF[8*(i-BASE_AT) +: 8] : cis_pkg::NULL_BYTE; // [RQ9]
		end else if (i < SUB_AT) begin
			// One bit per configuration register, set when it exists
			b = PRESENCE_MASK[8*(i-MASK_AT) +: 8]; // [RQ10]
		end else if (i < CEND_AT) begin
			if (k == 0) begin
				b = cis_pkg::SUB_CODE; // [RQ12]
			end else if (k == 1) begin
				b = cis_pkg::SUB_LINK; // [RQ12]
			end else if (k == 2) begin
				b = cis_pkg::IF_NUMBER; // [RQ13]
			end else if (k == 3) begin
				b = cis_pkg::IF_NUMBER_EXT;
			end else if (k < cis_pkg::SUB_NULL_AT) begin
				b = ch; // [RQ14]
			end else if (k == cis_pkg::SUB_NULL_AT) begin
				b = cis_pkg::NULL_BYTE; // [RQ14]
			end else begin
				// Chain end, and the spare room of the area reads as end too
				b = cis_pkg::CHAIN_END; // [RQ11] [RQ14]
			end
		end else if (i == CEND_AT) begin
			b = cis_pkg::CHAIN_END; // [RQ11]
		end
		return b;
	endfunction : cis_byte

	// ********************************************
	// Read path
	// ********************************************

	logic [7:0] rdata_d;
	logic [7:0] rdata_q;
	logic [7:0] stat_byte;
	logic [6:0] wr_cnt_q;
	logic wr_seen_q;

	assign stat_byte = {wr_seen_q, wr_cnt_q};

	// Odd or unmapped addresses answer with a fixed byte, never stale data
	always_comb begin
		if (stat_hit) begin
			rdata_d = stat_byte;
		end else if (!even_hit) begin
			rdata_d = cis_pkg::UNMAPPED; // [RQ15]
		end else if (idx_i < CIS_LEN) begin
			rdata_d = cis_byte(idx_i, char_byte); // [RQ15]
		end else begin
			rdata_d = cis_pkg::UNMAPPED;
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= cis_pkg::RDATA_IDLE;
		end else if (rd) begin
			rdata_q <= rdata_d;
		end else begin
			rdata_q <= cis_pkg::RDATA_IDLE;
		end
	end

	assign rdata = rdata_q;

	// ********************************************
	// Write monitor
	// ********************************************

	// Tuple bytes are constants, so a host write can only be counted
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			wr_seen_q <= 1'b0;
		end else if (wr && !stat_hit) begin
			wr_seen_q <= 1'b1; // [RQ17]
		end else if (wr && stat_hit && wdata[cis_pkg::STAT_CLR_BIT]) begin
			wr_seen_q <= 1'b0;
		end
	end

	// Saturating count, so a runaway driver cannot wrap it back to zero
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			wr_cnt_q <= 7'h00;
		end else if (wr && stat_hit && wdata[cis_pkg::STAT_CLR_BIT]) begin
			wr_cnt_q <= 7'h00;
		end else if (wr && !stat_hit && wr_cnt_q != 7'h7F) begin
			wr_cnt_q <= wr_cnt_q + 7'h01; // [RQ17]
		end
	end

	assign wr_seen = wr_seen_q;

	// ********************************************
	// Checks
	// ********************************************

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);

	a_mid_code_byte: assert property (rd && addr == 12'h000 |=> rdata == cis_pkg::MID_CODE) // [RQ1]
		else $error("maker tuple code wrong");
	a_mid_link_floor: assert property (rd && addr == 12'h002 |=> rdata >= cis_pkg::MID_LINK_MIN) // [RQ2]
		else $error("maker tuple link below four");
	a_maker_fields: assert property (rd && addr == 12'h004 ##1 rd && addr == 12'h006
		|=> rdata == CARD_INFO && $past(rdata) == MAKER_CODE) // [RQ3]
		else $error("maker code or card info wrong");
	a_cfg_header: assert property (rd && int'(addr) == 2*CFG_AT |=> rdata == cis_pkg::CFG_CODE) // [RQ4]
		else $error("configuration tuple code wrong");
	a_cfg_link_len: assert property (rd && int'(addr) == 2*(CFG_AT+1)
		|=> int'(rdata) == cis_pkg::CFG_FIXED_LINK + BASE_N + MASK_M + cis_pkg::SUB_AREA_LEN) // [RQ4]
		else $error("configuration link wrong");
	a_size_packing: assert property (rd && int'(addr) == 2*(CFG_AT+2)
		|=> rdata[7:6] == 2'b00 && rdata[1:0] == BASE_SIZE && rdata[5:2] == 4'(MASK_SIZE)) // [RQ5] [RQ6] [RQ16]
		else $error("size byte packing wrong");
	a_last_index: assert property (rd && int'(addr) == 2*(CFG_AT+3) |=> rdata == {2'b00, LAST_INDEX}) // [RQ7]
		else $error("last configuration index wrong");
	a_base_even: assert property (rd && int'(addr) == 2*BASE_AT ##1 rd && int'(addr) == 2*(BASE_AT+1)
		|=> $past(rdata[0]) == 1'b0 && {rdata[3:0], $past(rdata)} <= cis_pkg::BASE_MAX) // [RQ9]
		else $error("configuration base odd or too high");
	a_mask_bits: assert property (rd && int'(addr) == 2*MASK_AT |=> rdata == PRESENCE_MASK[7:0]) // [RQ10]
		else $error("presence mask wrong");
	a_sub_head: assert property (rd && int'(addr) == 2*SUB_AT ##1 rd && int'(addr) == 2*(SUB_AT+1)
		|=> $past(rdata) == cis_pkg::SUB_CODE && rdata == cis_pkg::SUB_LINK) // [RQ11] [RQ12]
		else $error("interface sub-tuple header wrong");
	a_if_number: assert property (rd && int'(addr) == 2*(SUB_AT+2) |=> rdata == cis_pkg::IF_NUMBER) // [RQ13]
		else $error("interface number wrong");
	a_name_end: assert property (rd && int'(addr) == 2*(SUB_AT+cis_pkg::SUB_NULL_AT)
		##1 rd && int'(addr) == 2*(SUB_AT+cis_pkg::SUB_END_AT)
		|=> $past(rdata) == cis_pkg::NULL_BYTE && rdata == cis_pkg::CHAIN_END) // [RQ14]
		else $error("name terminator or chain end wrong");
	a_odd_empty: assert property (rd && addr[0] |=> rdata == cis_pkg::UNMAPPED) // [RQ15]
		else $error("odd address returned data");
	a_rdata_window: assert property (!rd |=> rdata == cis_pkg::RDATA_IDLE)
		else $error("read data outside its cycle");
	a_write_inert: assert property (wr && addr == 12'h000 ##1 rd && addr == 12'h000
		|=> rdata == cis_pkg::MID_CODE) // [RQ17]
		else $error("write altered a tuple byte");
	a_write_flag: assert property (wr && !stat_hit |=> wr_seen) // [RQ17]
		else $error("write not flagged");

	c_full_chain_end: cover property (rd && int'(addr) == 2*CEND_AT ##1 rdata == cis_pkg::CHAIN_END);
	c_write_then_read: cover property (wr && !stat_hit ##1 rd && int'(addr) == 0);
	c_flag_cleared: cover property (wr_seen ##1 wr && stat_hit && wdata[0] ##1 !wr_seen);

endmodule : cis_rom

// ---- testbench/cis_host_model.sv ----
`timescale 1ns/1ps
// ********************************************
// Host attribute-memory reader model
// ********************************************
module cis_host_model (
	input logic sys_clk,
	input logic [7:0] rdata,
	output logic [11:0] addr,
	output logic [7:0] wdata,
	output logic wr,
	output logic rd
);

	// Idle bus; address is inverted after each access, and write data after each write, so stale values never help
	initial begin
		addr = 12'h0AA;
		wdata = 8'h55;
		wr = 1'b0;
		rd = 1'b0;
	end

	// One read: strobe for one cycle, data taken in the cycle after it
	task automatic rd_byte(input logic [11:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge sys_clk);
		rd <= 1'b0;
		addr <= ~a;
		#1;
		d = rdata;
	endtask : rd_byte

	// One write: strobe for one cycle, no answer
	task automatic wr_byte(input logic [11:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge sys_clk);
		wr <= 1'b0;
		addr <= ~a;
		wdata <= ~d;
		#1;
	endtask : wr_byte

	// Two reads with no gap: the strobe stays high while the address steps
	task automatic rd_two(input logic [11:0] a0, input logic [11:0] a1, output logic [7:0] d0,
		output logic [7:0] d1);
		@(posedge sys_clk);
		rd <= 1'b1;
		addr <= a0;
		@(posedge sys_clk);
		addr <= a1;
		#1;
		d0 = rdata;
		@(posedge sys_clk);
		rd <= 1'b0;
		addr <= ~a1;
		#1;
		d1 = rdata;
	endtask : rd_two

	// A write directly followed by a read of the same address
	task automatic wr_rd(input logic [11:0] a, input logic [7:0] wd, output logic [7:0] d);
		@(posedge sys_clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= wd;
		@(posedge sys_clk);
		wr <= 1'b0;
		rd <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		addr <= ~a;
		wdata <= ~wd;
		#1;
		d = rdata;
	endtask : wr_rd

	// Number of table entries the host walks; the configuration tuple starts at byte 6
	task automatic scan_count(output logic [7:0] n);
		logic [7:0] last;
		rd_byte(12'h012, last);
		n = last + 8'h01; // Scan ends after the entry equal to the last index
	endtask : scan_count

endmodule : cis_host_model

// ---- testbench/cis_rom_tb_top.sv ----
`timescale 1ns/1ps
// ********************************************
// Card information structure testbench
// ********************************************
module cis_rom_tb_top;

	localparam logic [8*cis_pkg::NAME_LEN-1:0] NAME_STR = "XIF_V1.00"; // Arbitrary neutral name
	logic sys_clk;
	logic nrst;
	logic [11:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic wr;
	logic rd;
	logic wr_seen;
	int err_total;
	int cmp_count;
	int cyc = 0;
	logic [7:0] exp_q [0:32];

	// Non-default contents so that swapped or missing fields show up
	cis_rom #(.MAKER_CODE(8'h5A), .CARD_INFO(8'h3C), .LAST_INDEX(6'h05), .CFG_BASE(12'h3FE),
		.PRESENCE_MASK(32'h0000_001F), .IF_NAME(NAME_STR)) uut (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.addr(addr),
		.wdata(wdata),
		.wr(wr),
		.rd(rd),
		.rdata(rdata),
		.wr_seen(wr_seen)
	);

	cis_host_model host (
		.sys_clk(sys_clk),
		.rdata(rdata),
		.addr(addr),
		.wdata(wdata),
		.wr(wr),
		.rd(rd)
	);

	// ********************************************
	// Clock, timeout and reporting
	// ********************************************
	initial sys_clk = 1'b0;
	always #20 sys_clk = ~sys_clk;

	// Whole run needs well under 400 cycles
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			err_total++;
			print_verdict();
		end
	end

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", what, exp, got);
			err_total++;
		end
	endtask : check

	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : print_verdict

	// ********************************************
	// Scenarios
	// ********************************************
	// Outputs stay quiet while reset is held
	task automatic t_reset();
		check("rdata in reset", 8'h00, rdata);
		check("wr_seen in reset", 8'h00, {7'h00, wr_seen});
	endtask : t_reset

	// Walks a span of structure bytes at even addresses
	task automatic t_bytes(input int lo, input int hi);
		logic [7:0] d;
		for (int i = lo; i <= hi; i++) begin
			host.rd_byte(12'(2 * i), d);
			check($sformatf("byte %0d", i), exp_q[i], d);
		end
	endtask : t_bytes

	// Back-to-back reads across field pairs, as a host burst would do them
	task automatic t_pairs();
		logic [7:0] d0;
		logic [7:0] d1;
		host.rd_two(12'h004, 12'h006, d0, d1);
		check("pair byte 2", exp_q[2], d0);
		check("pair byte 3", exp_q[3], d1);
		host.rd_two(12'h014, 12'h016, d0, d1);
		check("pair byte 10", exp_q[10], d0);
		check("pair byte 11", exp_q[11], d1);
		host.rd_two(12'h01A, 12'h01C, d0, d1);
		check("pair byte 13", exp_q[13], d0);
		check("pair byte 14", exp_q[14], d1);
		host.rd_two(12'h034, 12'h036, d0, d1);
		check("pair byte 26", exp_q[26], d0);
		check("pair byte 27", exp_q[27], d1);
	endtask : t_pairs

	// Odd addresses carry nothing, and read data lasts one cycle only
	task automatic t_odd();
		logic [7:0] d;
		for (int i = 0; i <= 32; i++) begin
			host.rd_byte(12'(2 * i + 1), d);
			check($sformatf("odd %0d", i), 8'h00, d);
		end
		host.rd_byte(12'h000, d);
		@(posedge sys_clk);
		#1;
		check("rdata after read", 8'h00, rdata);
	endtask : t_odd

	// Writes into the tuple area leave it unchanged but are noted
	task automatic t_write();
		logic [7:0] d;
		host.wr_rd(12'h000, 8'hAA, d);
		check("byte 0 after write", exp_q[0], d);
		host.wr_byte(12'h01A, 8'h55);
		check("wr_seen set", 8'h01, {7'h00, wr_seen});
		host.rd_byte(12'h000, d);
		check("byte 0 kept", exp_q[0], d);
		host.rd_byte(12'h01A, d);
		check("byte 13 kept", exp_q[13], d);
		host.rd_byte(12'h7F0, d);
		check("status", 8'h82, d);
		host.wr_byte(12'h7F0, 8'h01);
		check("wr_seen cleared", 8'h00, {7'h00, wr_seen});
		host.rd_byte(12'h7F0, d);
		check("status cleared", 8'h00, d);
	endtask : t_write

	// Host scan length follows the last index
	task automatic t_scan();
		logic [7:0] n;
		host.scan_count(n);
		check("scan length", 8'h06, n);
	endtask : t_scan

	// ********************************************
	// Main sequence
	// ********************************************
	initial begin
		nrst = 1'b0;
		err_total = 0;
		cmp_count = 0;
		exp_q[0] = 8'h20;
		exp_q[1] = 8'h04;
		exp_q[2] = 8'h5A;
		exp_q[3] = 8'h3C;
		exp_q[4] = 8'h00;
		exp_q[5] = 8'h00;
		exp_q[6] = 8'h1A;
		exp_q[7] = 8'h1B; // Five plus two base bytes, one mask byte, nineteen sub-tuple bytes
		exp_q[8] = 8'h01; // Mask size 0 above base size 1
		exp_q[9] = 8'h05;
		exp_q[10] = 8'hFE; // Base address low byte first
		exp_q[11] = 8'h03;
		exp_q[12] = 8'h1F;
		exp_q[13] = 8'hC0;
		exp_q[14] = 8'h0B;
		exp_q[15] = 8'h41;
		exp_q[16] = 8'h03;
		for (int i = 0; i < 9; i++) begin
			exp_q[17 + i] = NAME_STR[8 * (8 - i) +: 8];
		end
		exp_q[26] = 8'h00;
		for (int i = 27; i <= 32; i++) begin
			exp_q[i] = 8'hFF;
		end
		@(posedge sys_clk);
		#1;
		t_reset();
		@(posedge sys_clk);
		nrst <= 1'b1;
		t_bytes(0, 3);
		t_bytes(6, 12);
		t_bytes(13, 32);
		t_pairs();
		t_odd();
		t_write();
		t_scan();
		print_verdict();
	end

endmodule : cis_rom_tb_top
